//--- dv/rsirq_link_sva.sv
// assertions on the register port and irq pin between host and device
`default_nettype none
module rsirq_link_sva (
   // clock and reset
   input wire logic                   CLOCK,
   input wire logic                   SYS_RST,
   // register port
   input wire rsirq_pkg::rsirq_byte_t reg_addr,
   input wire rsirq_pkg::rsirq_byte_t reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire rsirq_pkg::rsirq_byte_t reg_rdata,
   input wire logic                   reg_ack,
   // irq and serial pins
   input wire logic                   irq_o,
   input wire logic                   irq_oe,
   input wire logic                   irq_pull,
   input wire logic                   irq_line,
   input wire logic                   serial_data_pin,
   input wire logic                   serial_valid_pin
);
   import rsirq_pkg::*;
   logic [1:0] cfg_q;
   logic [1:0] cfg_p;
   logic [3:0] sctl_q;
   logic [7:0] ien_q;
   logic [7:0] ien_p;
   logic       live_q;
   logic       calm;
   logic       asserted;
   ////////////////////////////////////////////////////////////////////////////////
   // shadow copies; the _p copies lag one edge because the pin is registered
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cfg_q <= 2'h1;
         cfg_p <= 2'h1;
         sctl_q <= 4'h3;
         ien_q <= 8'h00;
         ien_p <= 8'h00;
         live_q <= 1'b0;
      end else begin
         live_q <= 1'b1;
         cfg_p <= cfg_q;
         ien_p <= ien_q;
         if (reg_wr && reg_addr == 8'h05) cfg_q <= reg_wdata[1:0];
         if (reg_wr && reg_addr == 8'h06) sctl_q <= reg_wdata[3:0];
         if (reg_wr && reg_addr == 8'h07) ien_q <= reg_wdata;
      end
   end
   assign calm = live_q && cfg_q == cfg_p && ien_q == ien_p;
   assign asserted = cfg_q[1] ? irq_oe : (irq_o ~^ cfg_q[0]);
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SYS_RST);
   sequence s_strobe;
      reg_wr || reg_rd;
   endsequence
   property p_open_source;
      calm && cfg_q == 2'h3 && irq_oe |-> irq_o;
   endproperty
   a_open_source: assert property (p_open_source) else $error("open source drives low");
   property p_open_drain;
      calm && cfg_q == 2'h2 && irq_oe |-> !irq_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open drain drives high");
   property p_push_pull;
      calm && !cfg_q[1] |-> irq_oe;
   endproperty
   a_push_pull: assert property (p_push_pull) else $error("push pull pin floats");
   property p_quiet;
      calm && ien_q == 8'h00 |-> !asserted;
   endproperty
   a_quiet: assert property (p_quiet) else $error("pin asserted with no enable");
   property p_ack_next;
      s_strobe |=> reg_ack;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("access not acknowledged");
   property p_ack_caused;
      reg_ack |-> $past(reg_rd) || $past(reg_wr);
   endproperty
   a_ack_caused: assert property (p_ack_caused) else $error("ack without access");
   property p_one_strobe;
      !(reg_wr && reg_rd);
   endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("read and write together");
   property p_cfg_read;
      reg_rd && reg_addr == 8'h05 |=> reg_rdata == {6'h00, cfg_q};
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("pin config readback");
   property p_sctl_read;
      reg_rd && reg_addr == 8'h06 |=> reg_rdata == {4'h0, sctl_q};
   endproperty
   a_sctl_read: assert property (p_sctl_read) else $error("serdes control readback");
   property p_ien_read;
      reg_rd && reg_addr == 8'h07 |=> reg_rdata == ien_q;
   endproperty
   a_ien_read: assert property (p_ien_read) else $error("irq enable readback");
   property p_bit_mode;
      $rose(serial_valid_pin) |-> !sctl_q[3];
   endproperty
   a_bit_mode: assert property (p_bit_mode) else $error("serial bit in serdes mode");
   c_status_read: cover property (reg_rd && reg_addr == 8'h08);
   c_pin_float: cover property (cfg_q[1] && !irq_oe ##1 irq_oe);
   c_serial_bit: cover property ($rose(serial_valid_pin));
endmodule
`default_nettype wire

//--- dv/rx_serdes_irq_control_test.sv
// bench: apb into the host, bit streams into the device, both ends joined
`default_nettype none
module rx_serdes_irq_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rsirq_pkg::*;
   logic        CLOCK = 1'b0;
   logic        SYS_RST = 1'b1;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic        RX_EN = 1'b0;
   logic [1:0]  RX_BIT_TICK = 2'h0;
   logic [1:0]  RX_BIT_VALID = 2'h0;
   logic [1:0]  RX_BIT_DATA = 2'h0;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic        IRQ;
   logic        SERDES_MODE;
   logic [31:0] rd_v;
   logic        err_v;
   int          err_total = 0;
   int          comparisons = 0;
   rsirq_if link ();
   rsirq_device u_rsirq_device (.CLOCK, .SYS_RST, .LINK(link), .RX_EN, .RX_BIT_TICK,
      .RX_BIT_VALID, .RX_BIT_DATA, .SERDES_MODE);
   rsirq_host u_rsirq_host (.CLOCK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
      .PRDATA, .PREADY, .PSLVERR, .IRQ, .LINK(link));
   rsirq_link_sva u_rsirq_link_sva (.CLOCK, .SYS_RST, .reg_addr(link.reg_addr),
      .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
      .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .irq_o(link.irq_o),
      .irq_oe(link.irq_oe), .irq_pull(link.irq_pull), .irq_line(link.irq_line),
      .serial_data_pin(link.serial_data_pin), .serial_valid_pin(link.serial_valid_pin));
   always #4 CLOCK = ~CLOCK;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      while (PREADY !== 1'b1) @(posedge CLOCK);
      rd_v = PRDATA;
      err_v = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // one device access through the host command register, polled until idle
   task automatic dev(input logic wr, input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, 8'h00, {15'h0, wr, d, a});
      for (int i = 0; i < 20; i++) begin
         apb(1'b0, 8'h04, 32'h0);
         if (rd_v[8] === 1'b0) break;
      end
      chk("busy", 32'h0, {31'h0, rd_v[8]});
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] m,
                         input logic [7:0] e);
      dev(1'b0, a, 8'h00);
      chk(what, {24'h0, e}, {24'h0, rd_v[7:0] & m});
   endtask
   task automatic tick(input logic [1:0] ch, input logic [1:0] v, input logic [1:0] d);
      @(posedge CLOCK);
      RX_BIT_TICK <= ch;
      RX_BIT_VALID <= v;
      RX_BIT_DATA <= d;
      @(posedge CLOCK);
      RX_BIT_TICK <= 2'h0;
      repeat (2) @(posedge CLOCK);
   endtask
   task automatic send_bytes(input logic [7:0] a, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) tick(2'h3, 2'h3, {b[i], a[i]});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("serdes mode", 32'h0, {31'h0, SERDES_MODE});
      rd_chk("pin config", 8'h05, 8'hFF, 8'h01);
      rd_chk("serdes control", 8'h06, 8'hFF, 8'h03);
      rd_chk("irq enable", 8'h07, 8'hFF, 8'h00);
      dev(1'b1, 8'h07, 8'hA5);
      rd_chk("irq enable", 8'h07, 8'hFF, 8'hA5);
      dev(1'b1, 8'h06, 8'hF3);
      apb(1'b0, 8'h00, 32'h0);
      chk("command", 32'h00010306, rd_v);
      dev(1'b1, 8'h07, 8'h00);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err_v});
      chk("unmapped data", 32'h0, rd_v);
      $display("test reset done");
   endtask
   task automatic t_pins;
      for (int s = 0; s < 4; s++) begin
         dev(1'b1, 8'h05, 8'(s));
         apb(1'b1, 8'h08, 32'(s));
         dev(1'b1, 8'h07, 8'h08);
         apb(1'b1, 8'h10, (s > 1) ? 32'h2 : 32'h0);
         apb(1'b1, 8'h0C, 32'h7);
         @(negedge CLOCK);
         chk("idle line", {31'h0, ~s[0]}, {31'h0, link.irq_line});
         chk("idle drive", {31'h0, ~s[1]}, {31'h0, link.irq_oe});
         dev(1'b0, 8'h09, 8'h00);
         repeat (2) @(negedge CLOCK);
         chk("active line", {31'h0, s[0]}, {31'h0, link.irq_line});
         chk("host irq", (s > 1) ? 32'h1 : 32'h0, {31'h0, IRQ});
         rd_chk("status", 8'h08, 8'hFF, 8'h04);
         chk("cleared line", {31'h0, ~s[0]}, {31'h0, link.irq_line});
         apb(1'b1, 8'h0C, 32'h7);
         @(negedge CLOCK);
         chk("host irq clear", 32'h0, {31'h0, IRQ});
      end
      dev(1'b1, 8'h05, 8'h01);
      apb(1'b1, 8'h08, 32'h1);
      dev(1'b1, 8'h07, 8'h00);
      $display("test pins done");
   endtask
   task automatic t_bytes;
      dev(1'b1, 8'h06, 8'h0F);
      chk("serdes mode", 32'h1, {31'h0, SERDES_MODE});
      send_bytes(8'hA5, 8'h3C);
      rd_chk("status", 8'h08, 8'hFF, 8'h99);
      send_bytes(8'h5A, 8'hC3);
      rd_chk("status", 8'h08, 8'hFF, 8'hDD);
      rd_chk("status", 8'h08, 8'hFF, 8'h99);
      rd_chk("data a", 8'h09, 8'hFF, 8'h5A);
      rd_chk("data b", 8'h0B, 8'hFF, 8'hC3);
      $display("test bytes done");
   endtask
   task automatic t_eof;
      for (int k = 0; k < 2; k++) begin
         dev(1'b1, 8'h06, 8'h08 | 8'(3 * k));
         @(posedge CLOCK);
         RX_EN <= 1'b0;
         @(posedge CLOCK);
         RX_EN <= 1'b1;
         repeat (3) tick(2'h1, 2'h0, 2'h0);
         rd_chk("before frame", 8'h08, 8'h07, 8'h00);
         tick(2'h1, 2'h1, 2'h1);
         tick(2'h1, 2'h1, 2'h0);
         tick(2'h1, 2'h1, 2'h1);
         repeat (3 * k) tick(2'h1, 2'h0, 2'h0);
         rd_chk("in gap", 8'h08, 8'h07, 8'h00);
         tick(2'h1, 2'h0, 2'h0);
         rd_chk("frame end", 8'h08, 8'h0F, 8'h03);
         rd_chk("partial byte", 8'h09, 8'hFF, 8'h05);
      end
      $display("test eof done");
   endtask
   task automatic t_serial;
      dev(1'b1, 8'h06, 8'h03);
      chk("serdes mode", 32'h0, {31'h0, SERDES_MODE});
      for (int b = 0; b < 2; b++) begin
         tick(2'h1, 2'h1, {1'b0, ~b[0]});
         chk("serial data", {31'h0, ~b[0]}, {31'h0, link.serial_data_pin});
         apb(1'b0, 8'h04, 32'h0);
         chk("host serial bit", {31'h0, ~b[0]}, {31'h0, rd_v[10]});
      end
      $display("test serial done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      RX_EN <= 1'b1;
      t_reset();
      t_pins();
      t_bytes();
      t_eof();
      t_serial();
      tally_and_finish();
   end
   // whole run needs a few hundred cycles
   initial begin
      repeat (30000) @(posedge CLOCK);
      err_total++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

//--- hdl/rsirq_device.sv
// device end: config, serdes control, rx data registers, status and irq pin
`default_nettype none
`include "rsirq_regs.svh"
// Notes on behaviour
// - two-bit field picks irq pin drive style
// - control bit 3 selects serdes or bit-serial
// - serdes payload moves one byte per access
// - bit-serial: host handles bits on serial pins
// - host should prefer serdes over bit-serial
// - three-bit length sets end-of-frame gap
// - frame end only after a valid bit
// - frame end loads partial byte, flags eof
// - length zero: eof at first invalid bit
// - reading empty data register flags underflow
// - load over unread data flags overflow
// - every load into data register flags full
// - status read clears pending eof
// - enable bits: B high nibble, A low
// - host writes zeros into reserved bits
// - flags set regardless of enables, pollable
// - status read clears overflow and underflow
module rsirq_device (
   // clock and reset
   input  wire logic        CLOCK,
   input  wire logic        SYS_RST,
   // link to host
   rsirq_if.dev             LINK,
   // receiver side, index 0 is channel A
   input  wire logic        RX_EN,
   input  wire logic [1:0]  RX_BIT_TICK,
   input  wire logic [1:0]  RX_BIT_VALID,
   input  wire logic [1:0]  RX_BIT_DATA,
   // mode seen by the radio
   output logic             SERDES_MODE
);
   import rsirq_pkg::*;

   rsirq_byte_t cfg_q, cfg_d, sctl_q, sctl_d, ien_q, ien_d;
   rsirq_byte_t data_q [2];
   rsirq_byte_t data_d [2];
   rsirq_byte_t rdata_q, rdata_d;
   logic [1:0]  full_q, full_d, vld_q, vld_d, ov_q, ov_d, uf_q, uf_d, eof_q, eof_d;
   logic [1:0]  ld, ld_all, eof_ev, rd_data;
   rsirq_byte_t ld_data [2];
   logic        ack_q, ack_d, rd_stat, ser_en, chan_en;
   logic        irq_o_q, irq_o_d, irq_oe_q, irq_oe_d, asserted;
   logic        sd_q, sd_d, sv_q, sv_d;
   rsirq_byte_t status, pending;

   ////////////////////////////////////////////////////////////////////////////
   // receive channels
   assign ser_en  = sctl_q[`RSIRQ_SCTL_EN_BIT];
   // leaving receive or serdes mode drops any partial byte
   assign chan_en = RX_EN & ser_en;

   for (genvar c = 0; c < 2; c++) begin : g_chan
      rsirq_rx_chan u_chan (
         .clk       (CLOCK),
         .rst       (SYS_RST),
         .en        (chan_en),
         .bit_tick  (RX_BIT_TICK[c]),
         .bit_valid (RX_BIT_VALID[c]),
         .bit_data  (RX_BIT_DATA[c]),
         .eof_len   (sctl_q[2:0]),
         .ld        (ld[c]),
         .ld_data   (ld_data[c]),
         .ld_all    (ld_all[c]),
         .eof_ev    (eof_ev[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // register access and flags
   // one strobe aimed at one register
   function automatic logic hit(input logic stb, input rsirq_byte_t a, input rsirq_byte_t ofs);
      hit = stb && (a == ofs);
   endfunction

   assign rd_stat    = hit(LINK.reg_rd, LINK.reg_addr, `RSIRQ_STAT_OFS);
   assign rd_data[0] = hit(LINK.reg_rd, LINK.reg_addr, `RSIRQ_DATA_A_OFS);
   assign rd_data[1] = hit(LINK.reg_rd, LINK.reg_addr, `RSIRQ_DATA_B_OFS);

   // status reads zero outside receive; flags keep counting underneath
   assign status = RX_EN ? {vld_q[1], ov_q[1] | uf_q[1], eof_q[1], full_q[1],
                            vld_q[0], ov_q[0] | uf_q[0], eof_q[0], full_q[0]} : 8'h00;
   assign pending = {uf_q[1], ov_q[1], eof_q[1], full_q[1],
                     uf_q[0], ov_q[0], eof_q[0], full_q[0]};

   always_comb begin
      cfg_d   = cfg_q;
      sctl_d  = sctl_q;
      ien_d   = ien_q;
      rdata_d = rdata_q;
      ack_d   = LINK.reg_wr | LINK.reg_rd;
      // reserved bits are not stored, so they read back as zero
      if (LINK.reg_wr) begin
         case (LINK.reg_addr)
            `RSIRQ_CFG_OFS:  cfg_d  = LINK.reg_wdata & `RSIRQ_CFG_MASK;
            `RSIRQ_SCTL_OFS: sctl_d = LINK.reg_wdata & `RSIRQ_SCTL_MASK;
            `RSIRQ_IEN_OFS:  ien_d  = LINK.reg_wdata;
            default:         ;
         endcase
      end
      if (LINK.reg_rd) begin
         case (LINK.reg_addr)
            `RSIRQ_CFG_OFS:    rdata_d = cfg_q;
            `RSIRQ_SCTL_OFS:   rdata_d = sctl_q;
            `RSIRQ_IEN_OFS:    rdata_d = ien_q;
            `RSIRQ_STAT_OFS:   rdata_d = status;
            `RSIRQ_DATA_A_OFS: rdata_d = data_q[0];
            `RSIRQ_DATA_B_OFS: rdata_d = data_q[1];
            default:           rdata_d = 8'h00;
         endcase
      end
      for (int c = 0; c < 2; c++) begin
         data_d[c] = ld[c] ? ld_data[c] : data_q[c];
         vld_d[c]  = ld[c] ? ld_all[c] : vld_q[c];
         // set wins over clear in every flag below
         full_d[c] = ld[c] | (full_q[c] & ~rd_data[c]);
         ov_d[c]   = (ld[c] & full_q[c] & ~rd_data[c]) | (ov_q[c] & ~rd_stat);
         uf_d[c]   = (rd_data[c] & ~full_q[c]) | (uf_q[c] & ~rd_stat);
         eof_d[c]  = eof_ev[c] | (eof_q[c] & ~rd_stat);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // irq pin and bit-serial pins
   // full stays pending until its data register is read
   assign asserted = |(pending & ien_q);

   always_comb begin
      case (cfg_q[1:0])
         2'h3: begin
            irq_o_d  = 1'b1;
            irq_oe_d = asserted;
         end
         2'h2: begin
            irq_o_d  = 1'b0;
            irq_oe_d = asserted;
         end
         2'h1: begin
            irq_o_d  = asserted;
            irq_oe_d = 1'b1;
         end
         default: begin
            irq_o_d  = ~asserted;
            irq_oe_d = 1'b1;
         end
      endcase
      // bit-serial mode forwards channel A bits; timing is the host's problem
      sv_d = RX_EN & ~ser_en & RX_BIT_TICK[0] & RX_BIT_VALID[0];
      sd_d = sv_d ? RX_BIT_DATA[0] : sd_q;
   end

   // pin driven from flops so a style change never glitches the line
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_o_q  <= 1'b0;
         irq_oe_q <= 1'b0;
         sd_q     <= 1'b0;
         sv_q     <= 1'b0;
      end else begin
         irq_o_q  <= irq_o_d;
         irq_oe_q <= irq_oe_d;
         sd_q     <= sd_d;
         sv_q     <= sv_d;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cfg_q    <= `RSIRQ_CFG_RST;
         sctl_q   <= `RSIRQ_SCTL_RST;
         ien_q    <= `RSIRQ_IEN_RST;
         rdata_q  <= 8'h00;
         ack_q    <= 1'b0;
         data_q   <= '{8'h00, 8'h00};
         vld_q    <= 2'h0;
         full_q   <= 2'h0;
         ov_q     <= 2'h0;
         uf_q     <= 2'h0;
         eof_q    <= 2'h0;
      end else begin
         cfg_q    <= cfg_d;
         sctl_q   <= sctl_d;
         ien_q    <= ien_d;
         rdata_q  <= rdata_d;
         ack_q    <= ack_d;
         data_q   <= data_d;
         vld_q    <= vld_d;
         full_q   <= full_d;
         ov_q     <= ov_d;
         uf_q     <= uf_d;
         eof_q    <= eof_d;
      end
   end

   assign LINK.reg_rdata        = rdata_q;
   assign LINK.reg_ack          = ack_q;
   assign LINK.irq_o            = irq_o_q;
   assign LINK.irq_oe           = irq_oe_q;
   assign LINK.serial_data_pin  = sd_q;
   assign LINK.serial_valid_pin = sv_q;
   assign SERDES_MODE           = ser_en;
endmodule
`default_nettype wire

//--- hdl/rsirq_host.sv
// host end: apb command registers driving byte accesses to the device
`default_nettype none
`include "rsirq_regs.svh"
module rsirq_host (
   // clock and reset
   input  wire logic        CLOCK,
   input  wire logic        SYS_RST,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // interrupt
   output logic             IRQ,
   // link to device
   rsirq_if.host            LINK
);
   import rsirq_pkg::*;

   rsirq_hstate_e st_q, st_d;
   rsirq_byte_t   addr_q, addr_d, wdat_q, wdat_d, rdat_q, rdat_d;
   logic          write_q, write_d, seen_q, ser_q, ser_d, err_q, err_d;
   logic [1:0]    style_q, style_d;
   logic [2:0]    isr_q, isr_d, imr_q, imr_d, ev;
   logic [31:0]   prd_q, prd_d;
   logic          apb_wr, setup, line_asserted;

   // reserved device bits forced to zero whatever software sends
   function automatic rsirq_byte_t clean(input rsirq_byte_t a, input rsirq_byte_t d);
      case (a)
         `RSIRQ_CFG_OFS:  clean = d & `RSIRQ_CFG_MASK;
         `RSIRQ_SCTL_OFS: clean = d & `RSIRQ_SCTL_MASK;
         default:         clean = d;
      endcase
   endfunction

   assign apb_wr        = PSEL & PENABLE & PWRITE;
   assign setup         = PSEL & ~PENABLE;
   assign PREADY        = PSEL & PENABLE;
   assign line_asserted = LINK.irq_line ^ ~style_q[0];
   assign ev            = {LINK.serial_valid_pin, line_asserted & ~seen_q,
                           (st_q == H_WAIT) & LINK.reg_ack};

   ////////////////////////////////////////////////////////////////////////////
   // command engine and registers
   always_comb begin
      st_d    = st_q;
      addr_d  = addr_q;
      wdat_d  = wdat_q;
      write_d = write_q;
      rdat_d  = rdat_q;
      style_d = style_q;
      imr_d   = imr_q;
      isr_d   = isr_q | ev;
      ser_d   = LINK.serial_valid_pin ? LINK.serial_data_pin : ser_q;
      case (st_q)
         H_IDLE:   if (apb_wr && PADDR == `RSIRQ_H_CMD_OFS) begin
            // one byte per device access; serdes use is the intended path
            addr_d  = PWDATA[7:0];
            write_d = PWDATA[`RSIRQ_H_CMD_WR];
            wdat_d  = clean(PWDATA[7:0], PWDATA[15:8]);
            st_d    = H_STROBE;
         end
         H_STROBE: st_d = H_WAIT;
         H_WAIT:   if (LINK.reg_ack) begin
            st_d = H_IDLE;
            if (!write_q) rdat_d = LINK.reg_rdata;
         end
         default:  st_d = H_IDLE;
      endcase
      if (apb_wr) begin
         case (PADDR)
            `RSIRQ_H_CTRL_OFS: style_d = PWDATA[1:0];
            `RSIRQ_H_ISR_OFS:  isr_d   = (isr_q & ~PWDATA[2:0]) | ev;
            `RSIRQ_H_IMR_OFS:  imr_d   = PWDATA[2:0];
            default:           ;
         endcase
      end
      prd_d = prd_q;
      err_d = 1'b0;
      if (setup) begin
         case (PADDR)
            `RSIRQ_H_CMD_OFS:  prd_d = {15'h0000, write_q, wdat_q, addr_q};
            `RSIRQ_H_STAT_OFS: prd_d = {21'h000000, ser_q, line_asserted,
                                        st_q != H_IDLE, rdat_q};
            `RSIRQ_H_CTRL_OFS: prd_d = {30'h00000000, style_q};
            `RSIRQ_H_ISR_OFS:  prd_d = {29'h00000000, isr_q};
            `RSIRQ_H_IMR_OFS:  prd_d = {29'h00000000, imr_q};
            default: begin
               prd_d = 32'h00000000;
               err_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_q    <= H_IDLE;
         addr_q  <= 8'h00;
         wdat_q  <= 8'h00;
         write_q <= 1'b0;
         rdat_q  <= 8'h00;
         style_q <= `RSIRQ_H_CTRL_RST;
         isr_q   <= 3'h0;
         imr_q   <= 3'h0;
         seen_q  <= 1'b0;
         ser_q   <= 1'b0;
         prd_q   <= 32'h00000000;
         err_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         addr_q  <= addr_d;
         wdat_q  <= wdat_d;
         write_q <= write_d;
         rdat_q  <= rdat_d;
         style_q <= style_d;
         isr_q   <= isr_d;
         imr_q   <= imr_d;
         seen_q  <= line_asserted;
         ser_q   <= ser_d;
         prd_q   <= prd_d;
         err_q   <= err_d;
      end
   end

   assign PRDATA        = prd_q;
   assign PSLVERR       = err_q & PSEL & PENABLE;
   assign IRQ           = |(isr_q & imr_q);
   assign LINK.reg_addr  = addr_q;
   assign LINK.reg_wdata = wdat_q;
   assign LINK.reg_wr    = (st_q == H_STROBE) & write_q;
   assign LINK.reg_rd    = (st_q == H_STROBE) & ~write_q;
   // board pull matches the deasserted level of the open styles
   assign LINK.irq_pull  = ~style_q[0];
endmodule
`default_nettype wire

//--- hdl/rsirq_if.sv
// register port, interrupt pin and serial pins between host and device
`default_nettype none
interface rsirq_if;
   import rsirq_pkg::*;
   rsirq_byte_t reg_addr;
   rsirq_byte_t reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   rsirq_byte_t reg_rdata;
   logic        reg_ack;
   logic        irq_o;
   logic        irq_oe;
   logic        irq_pull;
   logic        irq_line;
   logic        serial_data_pin;
   logic        serial_valid_pin;
   // weak level of the undriven pin is set by the host's board pull
   assign irq_line = irq_oe ? irq_o : irq_pull;
   modport dev  (input reg_addr, reg_wdata, reg_wr, reg_rd,
                 output reg_rdata, reg_ack, irq_o, irq_oe, serial_data_pin, serial_valid_pin);
   modport host (output reg_addr, reg_wdata, reg_wr, reg_rd, irq_pull,
                 input reg_rdata, reg_ack, irq_line, serial_data_pin, serial_valid_pin);
endinterface
`default_nettype wire

//--- hdl/rsirq_pkg.sv
// types shared by both ends of the rx serdes irq link
`default_nettype none
package rsirq_pkg;
   typedef logic [7:0] rsirq_byte_t;
   typedef enum logic [1:0] {
      H_IDLE   = 2'b00,
      H_STROBE = 2'b01,
      H_WAIT   = 2'b10
   } rsirq_hstate_e;
endpackage
`default_nettype wire

//--- hdl/rsirq_regs.svh
// register map, field positions, reset values and masks of the rx serdes irq block
`ifndef RSIRQ_REGS_SVH
`define RSIRQ_REGS_SVH
// device map
`define RSIRQ_CFG_OFS     8'h05
`define RSIRQ_SCTL_OFS    8'h06
`define RSIRQ_IEN_OFS     8'h07
`define RSIRQ_STAT_OFS    8'h08
`define RSIRQ_DATA_A_OFS  8'h09
`define RSIRQ_DATA_B_OFS  8'h0B
`define RSIRQ_CFG_RST     8'h01
`define RSIRQ_SCTL_RST    8'h03
`define RSIRQ_IEN_RST     8'h00
`define RSIRQ_CFG_MASK    8'h03
`define RSIRQ_SCTL_MASK   8'h0F
`define RSIRQ_SCTL_EN_BIT 3
`define RSIRQ_BYTE_LAST   3'h7
// host map over apb
`define RSIRQ_H_CMD_OFS   8'h00
`define RSIRQ_H_STAT_OFS  8'h04
`define RSIRQ_H_CTRL_OFS  8'h08
`define RSIRQ_H_ISR_OFS   8'h0C
`define RSIRQ_H_IMR_OFS   8'h10
`define RSIRQ_H_CMD_WR    16
`define RSIRQ_H_CTRL_RST  2'h1
`endif

//--- hdl/rsirq_rx_chan.sv
// one receive channel: bit deserializer with end-of-frame gap detection
`default_nettype none
module rsirq_rx_chan (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // bit stream
   input  wire logic        en,
   input  wire logic        bit_tick,
   input  wire logic        bit_valid,
   input  wire logic        bit_data,
   input  wire logic [2:0]  eof_len,
   // load towards the data register
   output logic             ld,
   output logic [7:0]       ld_data,
   output logic             ld_all,
   output logic             eof_ev
);
   logic [7:0] sh_q, sh_d, dat_d;
   logic [2:0] cnt_q, cnt_d, gap_q, gap_d;
   logic       seen_q, seen_d, ld_d, all_d, eof_d;

   always_comb begin
      sh_d   = sh_q;
      cnt_d  = cnt_q;
      gap_d  = gap_q;
      seen_d = seen_q;
      dat_d  = ld_data;
      all_d  = ld_all;
      ld_d   = 1'b0;
      eof_d  = 1'b0;
      if (!en) begin
         cnt_d  = 3'h0;
         gap_d  = 3'h0;
         seen_d = 1'b0;
      end else if (bit_tick && bit_valid) begin
         sh_d   = {sh_q[6:0], bit_data};
         seen_d = 1'b1;
         gap_d  = 3'h0;
         cnt_d  = cnt_q + 3'h1;
         if (cnt_q == `RSIRQ_BYTE_LAST) begin
            ld_d  = 1'b1;
            dat_d = {sh_q[6:0], bit_data};
            all_d = 1'b1;
         end
      end else if (bit_tick && seen_q) begin
         // gap counts invalid bits beyond the first; len 0 fires at once
         if (gap_q == eof_len) begin
            eof_d  = 1'b1;
            seen_d = 1'b0;
            gap_d  = 3'h0;
            cnt_d  = 3'h0;
            if (cnt_q != 3'h0) begin
               // partial byte sits right-aligned, upper bits zero
               ld_d  = 1'b1;
               dat_d = sh_q & ~(8'hFF << cnt_q);
               all_d = 1'b0;
            end
         end else begin
            gap_d = gap_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sh_q    <= 8'h00;
         cnt_q   <= 3'h0;
         gap_q   <= 3'h0;
         seen_q  <= 1'b0;
         ld      <= 1'b0;
         ld_data <= 8'h00;
         ld_all  <= 1'b0;
         eof_ev  <= 1'b0;
      end else begin
         sh_q    <= sh_d;
         cnt_q   <= cnt_d;
         gap_q   <= gap_d;
         seen_q  <= seen_d;
         ld      <= ld_d;
         ld_data <= dat_d;
         ld_all  <= all_d;
         eof_ev  <= eof_d;
      end
   end
endmodule
`default_nettype wire
